// *** src/cbus_port_pkg.sv ***
// Constants, types and state encoding for the management register port
// Notes on behaviour
// - Read/write select high means register read, low means register write.
// - Device pulls open-drain active-low acknowledge to finish each read or write.
// - On reads the device drives register contents while acknowledge stays low.
// - Acknowledge stays low for as long as the host keeps select low.
// - Five-bit address, bit 4 most significant, selects one of 32 byte registers.
// - Open-drain interrupt pulls low while any unmasked cause bit is set.
// - Each interrupt cause has its own mask bit gating the interrupt output.
// - Odd parity over data; device always generates it on reads.
// - With checking enabled, bad write parity blocks the write and flags an error.
// - Port signals are sampled and driven on the local byte clock.
package cbus_port_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 32;
  localparam int NUM_EVENTS = 7;

  // Clock and synchroniser figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES = 2;

  // Register indices of the interrupt pair
  localparam logic [ADDR_W-1:0] IRQ_CAUSE_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 5'h01;

  // Field positions and reset values
  localparam int PARITY_ERR_BIT = 0;
  localparam logic [DATA_W-1:0] IRQ_CAUSE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic sel_n;
    logic rd_wr;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_data;
    logic reg_data_parity;
  } cbus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ACK = 2'b11,
    ST_DONE = 2'b10
  } port_state_t;

endpackage

// *** src/cbus_host_port.sv ***
// Management register port: select handshake, register file, interrupt cause and mask
`timescale 1ns/1ps
module cbus_host_port
  import cbus_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire cbus_req_t host_req_in,
  input wire logic write_parity_check_en_in,
  input wire logic [NUM_EVENTS-1:0] irq_event_in,
  output logic [DATA_W-1:0] reg_data_out,
  output logic reg_data_oe_out,
  output logic reg_data_parity_out,
  output logic reg_data_parity_oe_out,
  output logic ack_n_out,
  output logic ack_oe_out,
  output logic irq_n_out,
  output logic irq_oe_out,
  output logic [NUM_REGS*DATA_W-1:0] cfg_regs_out
);

  port_state_t state;
  port_state_t next_state;
  logic [SYNC_STAGES-1:0] sel_sync_chain;
  logic sel_n_sync;
  logic [DATA_W-1:0] regs [0:NUM_REGS-1];
  logic [DATA_W-1:0] irq_cause_reg;
  logic [DATA_W-1:0] irq_mask_reg;
  logic read_cycle;
  logic parity_ok;
  logic write_ok;
  logic parity_fail;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] cause_events;
  logic [DATA_W-1:0] cause_clear;

  // Select synchroniser, only the last stage is used
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_sync_chain <= '1;
    end else begin
      sel_sync_chain <= {sel_sync_chain[SYNC_STAGES-2:0], host_req_in.sel_n};
    end
  end
  assign sel_n_sync = sel_sync_chain[SYNC_STAGES-1];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!sel_n_sync) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ST_ACK;
      end
      ST_ACK: begin
        if (sel_n_sync) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cycle decode and write parity check
  assign read_cycle = host_req_in.rd_wr;
  assign parity_ok = ^{host_req_in.reg_data, host_req_in.reg_data_parity};
  assign parity_fail = (state == ST_EXEC) && !read_cycle && write_parity_check_en_in
    && !parity_ok;
  assign write_ok = (state == ST_EXEC) && !read_cycle
    && (parity_ok || !write_parity_check_en_in);

  always_comb begin
    case (host_req_in.reg_addr)
      IRQ_CAUSE_ADDR: begin
        read_value = irq_cause_reg;
      end
      IRQ_MASK_ADDR: begin
        read_value = irq_mask_reg;
      end
      default: begin
        read_value = regs[host_req_in.reg_addr];
      end
    endcase
  end

  // General storage registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (write_ok) begin
      regs[host_req_in.reg_addr] <= host_req_in.reg_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_cfg
      assign cfg_regs_out[g*DATA_W +: DATA_W] = regs[g];
    end
  endgenerate

  // Mask register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (write_ok && host_req_in.reg_addr == IRQ_MASK_ADDR) begin
      irq_mask_reg <= host_req_in.reg_data;
    end
  end

  // Cause register: write one to clear, a new event wins over the clear
  assign cause_events = {irq_event_in, parity_fail};
  assign cause_clear = (write_ok && host_req_in.reg_addr == IRQ_CAUSE_ADDR)
    ? host_req_in.reg_data : '0;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_cause_reg <= IRQ_CAUSE_RESET;
    end else begin
      irq_cause_reg <= (irq_cause_reg & ~cause_clear) | cause_events;
    end
  end

  // Read data and parity, held while acknowledge is low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_data_out <= '0;
      reg_data_parity_out <= 1'b1;
    end else if (state == ST_EXEC && read_cycle) begin
      reg_data_out <= read_value;
      reg_data_parity_out <= ~^read_value;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_data_oe_out <= 1'b0;
    end else if (state == ST_EXEC) begin
      reg_data_oe_out <= read_cycle;
    end else if (next_state == ST_DONE || state == ST_IDLE) begin
      reg_data_oe_out <= 1'b0;
    end
  end
  assign reg_data_parity_oe_out = reg_data_oe_out;

  // Open-drain pins: the output level is always low, the enable pulls
  assign ack_n_out = 1'b0;
  assign ack_oe_out = (state == ST_ACK);
  assign irq_n_out = 1'b0;
  assign irq_oe_out = |(irq_cause_reg & irq_mask_reg);

  chk_ack_after_sel: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($fell(sel_n_sync) && state == ST_IDLE) |-> ##2 ack_oe_out)
    else $error("acknowledge not asserted two cycles after select");

  chk_ack_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ack_oe_out && !sel_n_sync) |=> ack_oe_out)
    else $error("acknowledge dropped while select low");

  chk_ack_release: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ack_oe_out && sel_n_sync) |=> (!ack_oe_out && !reg_data_oe_out) ##1 state == ST_IDLE)
    else $error("acknowledge or data not released after select high");

  chk_read_stable: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ack_oe_out && $past(ack_oe_out) && reg_data_oe_out) |-> $stable(reg_data_out))
    else $error("read data changed while acknowledge low");

  chk_read_drive: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ST_EXEC && read_cycle) |=> (reg_data_oe_out && ack_oe_out
      && reg_data_out == $past(read_value)))
    else $error("read cycle did not drive selected register");

  chk_read_parity: assert property (@(posedge clk_in) disable iff (!rstn_in)
    reg_data_oe_out |-> (^{reg_data_out, reg_data_parity_out}) == 1'b1)
    else $error("read parity is not odd");

  chk_parity_block: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ST_EXEC && !read_cycle && write_parity_check_en_in && !parity_ok)
      |=> (irq_cause_reg[PARITY_ERR_BIT] && $stable(irq_mask_reg) && $stable(cfg_regs_out)))
    else $error("bad write parity not blocked or not flagged");

  chk_mask_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (write_ok && host_req_in.reg_addr == IRQ_MASK_ADDR)
      |=> irq_mask_reg == $past(host_req_in.reg_data))
    else $error("mask register write lost");

  chk_irq_masked: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ($rose(irq_cause_reg[PARITY_ERR_BIT]) && irq_mask_reg[PARITY_ERR_BIT]) |-> irq_oe_out)
    else $error("unmasked cause did not raise interrupt");

  chk_sync_delay: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == ST_EXEC) |-> !$past(sel_n_sync))
    else $error("cycle started without synchronised select");

endmodule

// *** verification/cbus_host_model.sv ***
// Host model: runs select and acknowledge cycles on the management port
`timescale 1ns/1ps
module cbus_host_model
  import cbus_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic ack_n_in,
  input wire logic [DATA_W-1:0] reg_data_in,
  input wire logic reg_data_parity_in,
  output cbus_req_t host_req_out
);
  initial host_req_out = '{1'b1, 1'b1, 5'h00, 8'h00, 1'b1};
  // Extra select-low cycles in hold; ok drops if acknowledge misbehaves
  task automatic run(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic bad, input int hold, output logic [DATA_W-1:0] q, output logic p,
    output logic ok);
    int n;
    begin
      n = 0;
      ok = 1'b1;
      @(posedge clk_in) #2;
      host_req_out = '{1'b0, rd, a, d, ~^d ^ bad};
      while (ack_n_in !== 1'b0 && n < 20) begin
        @(posedge clk_in) #2;
        n++;
      end
      if (n >= 20) ok = 1'b0;
      repeat (hold) begin
        @(posedge clk_in) #2;
        if (ack_n_in !== 1'b0) ok = 1'b0;
      end
      q = reg_data_in;
      p = reg_data_parity_in;
      host_req_out = '{1'b1, ~rd, ~a, ~d, ~host_req_out.reg_data_parity};
      repeat (4) @(posedge clk_in) #2;
      if (ack_n_in !== 1'b1) ok = 1'b0;
      repeat (3) @(posedge clk_in) #2;
    end
  endtask
endmodule

// *** verification/phy_ctrl_bus_host_port_bench.sv ***
// Self-checking bench for the management register port
`timescale 1ns/1ps
module phy_ctrl_bus_host_port_bench;
  import cbus_port_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic chk_en = 1'b0;
  logic [NUM_EVENTS-1:0] ev = '0;
  cbus_req_t req;
  logic [DATA_W-1:0] rdata, q;
  logic rd_oe, par, par_oe, ackn, ack_oe, irqn, irq_oe, p, ok;
  logic [NUM_REGS*DATA_W-1:0] cfg;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  wire logic ack_pin = ack_oe ? ackn : 1'b1;
  wire logic irq_pin = irq_oe ? irqn : 1'b1;
  wire logic [DATA_W-1:0] bus = rd_oe ? rdata : ~rdata;
  wire logic bus_par = par_oe ? par : ~par;

  cbus_host_port u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .host_req_in(req),
    .write_parity_check_en_in(chk_en), .irq_event_in(ev), .reg_data_out(rdata),
    .reg_data_oe_out(rd_oe), .reg_data_parity_out(par), .reg_data_parity_oe_out(par_oe),
    .ack_n_out(ackn), .ack_oe_out(ack_oe), .irq_n_out(irqn), .irq_oe_out(irq_oe),
    .cfg_regs_out(cfg));
  cbus_host_model u_host (.clk_in(clk_in), .ack_n_in(ack_pin), .reg_data_in(bus),
    .reg_data_parity_in(bus_par), .host_req_out(req));

  initial forever #25 clk_in = ~clk_in;

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic bad);
    u_host.run(rd, a, d, bad, 2, q, p, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic t_reset();
    check({6'h00, ack_pin, irq_pin}, 8'h03);
    check({7'h00, |cfg}, 8'h00);
  endtask

  task automatic t_rw();
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 5'h1f : ((i == 1) ? 5'h02 : 5'h10);
      d = 8'ha5 ^ (8'h3c * i[7:0]);
      op(1'b0, a, d, 1'b0);
      check(cfg[a*DATA_W +: DATA_W], d);
      op(1'b1, a, 8'h00, 1'b0);
      check(q, d);
      check({7'h00, rd_oe}, 8'h00);
      check({7'h00, ^{q, p}}, 8'h01);
    end
  endtask

  task automatic t_parity();
    chk_en = 1'b1;
    op(1'b0, IRQ_MASK_ADDR, 8'h01, 1'b0);
    op(1'b1, IRQ_MASK_ADDR, 8'h00, 1'b0);
    check(q, 8'h01);
    op(1'b0, 5'h03, 8'h77, 1'b1);
    check(cfg[3*DATA_W +: DATA_W], 8'h00);
    check({7'h00, irq_pin}, 8'h00);
    op(1'b1, IRQ_CAUSE_ADDR, 8'h00, 1'b0);
    check(q, 8'h01);
    op(1'b0, IRQ_CAUSE_ADDR, 8'h01, 1'b0);
    check({7'h00, irq_pin}, 8'h01);
    op(1'b1, IRQ_CAUSE_ADDR, 8'h00, 1'b0);
    check(q, 8'h00);
    chk_en = 1'b0;
    op(1'b0, 5'h03, 8'h77, 1'b1);
    check(cfg[3*DATA_W +: DATA_W], 8'h77);
  endtask

  task automatic t_irq();
    op(1'b0, IRQ_MASK_ADDR, 8'h04, 1'b0);
    @(posedge clk_in) #2 ev = 7'h01;
    @(posedge clk_in) #2 ev = 7'h00;
    check({7'h00, irq_pin}, 8'h01);
    op(1'b1, IRQ_CAUSE_ADDR, 8'h00, 1'b0);
    check(q, 8'h02);
    @(posedge clk_in) #2 ev = 7'h02;
    @(posedge clk_in) #2 ev = 7'h00;
    check({7'h00, irq_pin}, 8'h00);
    op(1'b0, IRQ_CAUSE_ADDR, 8'h06, 1'b0);
    check({7'h00, irq_pin}, 8'h01);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge clk_in);
    #2 rstn_in = 1'b1;
    @(posedge clk_in) #2;
    t_reset();
    t_rw();
    t_parity();
    t_irq();
    results();
  end
endmodule
